// file: common/abpwm_regs.svh
// Command codes, parameter storage map, field positions and reset values of the backlight PWM block
// Assumes inclusion by bare name from rtl files and the bench
`ifndef ABPWM_REGS_SVH
`define ABPWM_REGS_SVH

`define ABPWM_CMD_PWM_CTRL 8'hb9
`define ABPWM_CMD_ADAPT 8'hb8
`define ABPWM_PWM_CTRL_NPARAM 4'h4
`define ABPWM_ADAPT_NPARAM 4'hb
`define ABPWM_RESET_BYTE 8'h00

`define ABPWM_ADDR_DUTY 4'h0
`define ABPWM_ADDR_AUX 4'h1
`define ABPWM_ADDR_CTRL 4'h2
`define ABPWM_ADDR_STEP 4'h3
`define ABPWM_ADDR_GAP0 4'h4
`define ABPWM_ADDR_GAP1 4'h5
`define ABPWM_ADDR_COEF0 4'h6
`define ABPWM_ADDR_COEF1 4'h7
`define ABPWM_ADDR_MODE 4'h8
`define ABPWM_ADDR_GMIN 4'h9
`define ABPWM_ADDR_ZERO 4'hf

`define ABPWM_CTRL_GSEL_BIT 4
`define ABPWM_CTRL_PINEN_BIT 3
`define ABPWM_MODE_INTERP0_BIT 0
`define ABPWM_MODE_INTERP1_BIT 1
`define ABPWM_MODE_BANK_BIT 2
`define ABPWM_CTRL_MASK 8'h18
`define ABPWM_FIELD5_MASK 8'h1f
`define ABPWM_MODE_MASK 8'h07
`define ABPWM_COEF_MAX 5'h10
`define ABPWM_PWM_PERIOD_LAST 8'hfe

`endif

// file: common/abpwm_pkg.sv
// Types shared by the backlight PWM block
// Assumes no other package
package abpwm_pkg;

	typedef enum logic [1:0] {
		ABPWM_CMD_IDLE,
		ABPWM_CMD_PWM,
		ABPWM_CMD_ADAPT
	} abpwm_cmd_state_t;

endpackage : abpwm_pkg

// file: rtl/abpwm_param_mem.sv
// Small parameter store: one write port, one registered read port, all words visible in parallel
// Assumes one clock; writes and reads qualified by the clock enable
`timescale 1ns/1ns
`default_nettype none
`include "abpwm_regs.svh"

module abpwm_param_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic core_ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data,
	output logic [WIDTH*DEPTH-1:0] contents
);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [WIDTH-1:0] rd_data_r;
	logic [WIDTH-1:0] rd_data_nxt;

	always_comb
	begin
		rd_data_nxt = rd_data_r;
		for (int i = 0; i < DEPTH; i++)
		begin
			mem_nxt[i] = mem_r[i];
		end
		if (core_ce && wr_en)
		begin
			mem_nxt[wr_addr] = wr_data;
		end
		if (core_ce && rd_en)
		begin
			rd_data_nxt = mem_r[rd_addr];
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_data_r <= '0;
			for (int i = 0; i < DEPTH; i++)
			begin
				mem_r[i] <= '0;
			end
		end
		else
		begin
			rd_data_r <= rd_data_nxt;
			for (int i = 0; i < DEPTH; i++)
			begin
				mem_r[i] <= mem_nxt[i];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++)
		begin : g_flat
			assign contents[g*WIDTH +: WIDTH] = mem_r[g];
		end
	endgenerate

	assign rd_data = rd_data_r;

endmodule : abpwm_param_mem

`default_nettype wire

// file: rtl/abpwm_top.sv
// Adaptive backlight parameter registers, threshold stepping and LED PWM gating
// Assumes command bytes, display state and frame timing come from logic on core_clk
`timescale 1ns/1ns
`default_nettype none
`include "abpwm_regs.svh"

module abpwm_top (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic core_ce,
	input wire logic cmd_valid,
	input wire logic cmd_dcx,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_data,
	input wire logic sleep_mode,
	input wire logic display_on,
	input wire logic pwm_on_request,
	input wire logic adaptive_backlight_enable,
	input wire logic [7:0] adaptive_backlight_factor,
	input wire logic frame_start,
	input wire logic [7:0] threshold_target,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic led_pwm_output,
	output logic led_pwm_pin_oe,
	output logic [7:0] pwm_readback_value,
	output logic [8:0] white_threshold_level,
	output logic interp_two_point,
	output logic [4:0] counter_gap_half,
	output logic [4:0] antiwhite_coeff,
	output logic [39:0] gamma_ref_values,
	output logic setting_inhibited
);

	////////////////////////////////////////////////////////////////////////////////
	// Command decoder and parameter store

	abpwm_pkg::abpwm_cmd_state_t cmd_state_r;
	abpwm_pkg::abpwm_cmd_state_t cmd_state_nxt;
	logic [3:0] pidx_r;
	logic [3:0] pidx_nxt;
	logic rsp_valid_r;
	logic rsp_valid_nxt;
	logic wr_en;
	logic rd_en;
	logic [3:0] addr;
	logic [7:0] wr_data;
	logic [127:0] contents;
	logic [7:0] mem_rd_data;
	logic param_cyc;

	function automatic logic [7:0] byte_mask(input logic [3:0] a);
		unique case (a)
			`ABPWM_ADDR_CTRL: byte_mask = `ABPWM_CTRL_MASK;
			`ABPWM_ADDR_GAP0, `ABPWM_ADDR_GAP1, `ABPWM_ADDR_COEF0, `ABPWM_ADDR_COEF1: byte_mask = `ABPWM_FIELD5_MASK;
			`ABPWM_ADDR_MODE: byte_mask = `ABPWM_MODE_MASK;
			default: byte_mask = 8'hff;
		endcase
	endfunction : byte_mask
	assign param_cyc = cmd_valid && cmd_dcx;
	always_comb
	begin
		cmd_state_nxt = cmd_state_r;
		pidx_nxt = pidx_r;
		addr = `ABPWM_ADDR_ZERO;
		wr_en = 1'b0;
		rd_en = 1'b0;
		rsp_valid_nxt = 1'b0;
		wr_data = cmd_data & byte_mask(addr);
		if (core_ce && cmd_valid && !cmd_dcx)
		begin
			pidx_nxt = 4'h0;
			cmd_state_nxt = (cmd_data == `ABPWM_CMD_PWM_CTRL) ? abpwm_pkg::ABPWM_CMD_PWM :
				(cmd_data == `ABPWM_CMD_ADAPT) ? abpwm_pkg::ABPWM_CMD_ADAPT : abpwm_pkg::ABPWM_CMD_IDLE;
		end
		else if (core_ce && param_cyc)
		begin
			unique case (cmd_state_r)
				abpwm_pkg::ABPWM_CMD_PWM:
				begin
					if (pidx_r != 4'h0 && pidx_r < `ABPWM_PWM_CTRL_NPARAM)
					begin
						addr = pidx_r - 4'h1;
					end
				end
				abpwm_pkg::ABPWM_CMD_ADAPT:
				begin
					if (pidx_r < `ABPWM_ADAPT_NPARAM)
					begin
						addr = pidx_r + `ABPWM_ADDR_STEP;
					end
				end
				abpwm_pkg::ABPWM_CMD_IDLE: addr = `ABPWM_ADDR_ZERO;
			endcase
			wr_data = cmd_data & byte_mask(addr);
			wr_en = cmd_wr && cmd_state_r != abpwm_pkg::ABPWM_CMD_IDLE && addr != `ABPWM_ADDR_ZERO;
			rd_en = !cmd_wr;
			rsp_valid_nxt = !cmd_wr;
			if (pidx_r != 4'hf)
			begin
				pidx_nxt = pidx_r + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cmd_state_r <= abpwm_pkg::ABPWM_CMD_IDLE;
			pidx_r <= 4'h0;
			rsp_valid_r <= 1'b0;
		end
		else if (core_ce)
		begin
			cmd_state_r <= cmd_state_nxt;
			pidx_r <= pidx_nxt;
			rsp_valid_r <= rsp_valid_nxt;
		end
	end

	abpwm_param_mem #(
		.WIDTH(8),
		.DEPTH(16),
		.AW(4)
	) u_mem (
		.core_clk(core_clk),
		.resetn(resetn),
		.core_ce(core_ce),
		.wr_en(wr_en),
		.wr_addr(addr),
		.wr_data(wr_data),
		.rd_en(rd_en),
		.rd_addr(addr),
		.rd_data(mem_rd_data),
		.contents(contents)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Field extraction with bank selection

	logic [7:0] duty_val;
	logic [7:0] ctrl_val;
	logic [7:0] mode_val;
	logic bank;
	logic gsel;
	logic pin_en;
	logic [3:0] step_sel;
	logic [4:0] gap_sel;
	logic [4:0] coef_sel;
	logic interp_sel;
	assign duty_val = contents[`ABPWM_ADDR_DUTY*8 +: 8];
	assign ctrl_val = contents[`ABPWM_ADDR_CTRL*8 +: 8];
	assign mode_val = contents[`ABPWM_ADDR_MODE*8 +: 8];
	assign bank = mode_val[`ABPWM_MODE_BANK_BIT];
	assign gsel = ctrl_val[`ABPWM_CTRL_GSEL_BIT];
	assign pin_en = ctrl_val[`ABPWM_CTRL_PINEN_BIT];
	always_comb
	begin
		step_sel = bank ? contents[`ABPWM_ADDR_STEP*8+4 +: 4] : contents[`ABPWM_ADDR_STEP*8 +: 4];
		gap_sel = bank ? contents[`ABPWM_ADDR_GAP1*8 +: 5] : contents[`ABPWM_ADDR_GAP0*8 +: 5];
		coef_sel = bank ? contents[`ABPWM_ADDR_COEF1*8 +: 5] : contents[`ABPWM_ADDR_COEF0*8 +: 5];
		interp_sel = bank ? mode_val[`ABPWM_MODE_INTERP1_BIT] : mode_val[`ABPWM_MODE_INTERP0_BIT];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Threshold stepping and parameter outputs

	logic [8:0] thr_r;
	logic [8:0] thr_nxt;
	logic [8:0] target2;
	logic interp_r;
	logic [4:0] gap_r;
	logic [4:0] coef_r;
	logic [39:0] gamma_r;
	logic inhib_r;
	logic inhib_nxt;
	assign target2 = {threshold_target, 1'b0};
	always_comb
	begin
		thr_nxt = thr_r;
		if (frame_start && thr_r < target2)
		begin
			thr_nxt = (target2 - thr_r > {5'h00, step_sel}) ? thr_r + {5'h00, step_sel} : target2;
		end
		else if (frame_start)
		begin
			thr_nxt = (thr_r - target2 > {5'h00, step_sel}) ? thr_r - {5'h00, step_sel} : target2;
		end
		inhib_nxt = step_sel == 4'h0 || gap_sel == 5'h00 || coef_sel > `ABPWM_COEF_MAX;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			thr_r <= 9'h000;
			interp_r <= 1'b0;
			gap_r <= 5'h00;
			coef_r <= 5'h00;
			gamma_r <= 40'h0;
			inhib_r <= 1'b0;
		end
		else if (core_ce)
		begin
			thr_r <= thr_nxt;
			interp_r <= interp_sel;
			gap_r <= gap_sel;
			coef_r <= coef_sel;
			gamma_r <= contents[`ABPWM_ADDR_GMIN*8 +: 40];
			inhib_r <= inhib_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// PWM generation and gating

	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [15:0] prod;
	logic [7:0] duty;
	logic gate_on;
	logic led_r;
	logic led_nxt;
	logic oe_r;
	logic [7:0] pwm_readback_value_r;
	assign prod = {8'h00, duty_val} * {8'h00, adaptive_backlight_factor};
	always_comb
	begin
		cnt_nxt = (cnt_r == `ABPWM_PWM_PERIOD_LAST) ? 8'h00 : cnt_r + 8'h01;
		duty = (!adaptive_backlight_enable || adaptive_backlight_factor == 8'hff) ? duty_val : prod[15:8];
		gate_on = gsel ? pwm_on_request : display_on;
		led_nxt = pin_en && gate_on && !sleep_mode && cnt_r < duty;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_r <= 8'h00;
			led_r <= 1'b0;
			oe_r <= 1'b0;
			pwm_readback_value_r <= 8'h00;
		end
		else if (core_ce)
		begin
			cnt_r <= cnt_nxt;
			led_r <= led_nxt;
			oe_r <= pin_en;
			pwm_readback_value_r <= duty;
		end
	end

	assign rsp_valid = rsp_valid_r;
	assign rsp_data = mem_rd_data;
	assign led_pwm_output = led_r;
	assign led_pwm_pin_oe = oe_r;
	assign pwm_readback_value = pwm_readback_value_r;
	assign white_threshold_level = thr_r;
	assign interp_two_point = interp_r;
	assign counter_gap_half = gap_r;
	assign antiwhite_coeff = coef_r;
	assign gamma_ref_values = gamma_r;
	assign setting_inhibited = inhib_r;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_sleep_forces_off: assert property (core_ce && sleep_mode |=> !led_pwm_output)
		else $error("LED PWM active during sleep");
	a_display_gate: assert property (core_ce && !gsel && !display_on |=> !led_pwm_output)
		else $error("LED PWM active with display off");
	a_request_gate: assert property (core_ce && gsel && !pwm_on_request |=> !led_pwm_output)
		else $error("LED PWM active without on request");
	a_pin_enable: assert property (core_ce && !pin_en |=> !led_pwm_output && !led_pwm_pin_oe)
		else $error("LED PWM pin driven while disabled");
	a_thr_hold: assert property (core_ce && !frame_start |=> $stable(white_threshold_level))
		else $error("Threshold moved outside frame start");
	a_thr_step: assert property (core_ce && frame_start && {1'b0, thr_r} + {6'h00, step_sel} <= {1'b0, target2}
		|=> white_threshold_level == $past(thr_r) + {5'h00, $past(step_sel)})
		else $error("Threshold step size wrong");
	a_interp_bank: assert property (core_ce |=> interp_two_point == $past(interp_sel))
		else $error("Interpolation bank mismatch");
	a_first_zero: assert property (core_ce && param_cyc && !cmd_wr && cmd_state_r == abpwm_pkg::ABPWM_CMD_PWM
		&& pidx_r == 4'h0 |=> rsp_valid && rsp_data == 8'h00)
		else $error("First PWM parameter not zero");
	a_manual_duty: assert property (core_ce && !adaptive_backlight_enable |=> pwm_readback_value == $past(duty_val))
		else $error("Manual duty not used");
	a_coef_inhib: assert property (core_ce && coef_sel > `ABPWM_COEF_MAX |=> setting_inhibited)
		else $error("Forbidden coefficient not flagged");

	c_pwm_pulse: cover property (led_pwm_output ##1 !led_pwm_output);
	c_bank_one: cover property (core_ce && bank && frame_start);
	c_read_back: cover property (rsp_valid && rsp_data != 8'h00);

endmodule : abpwm_top

`default_nettype wire

// file: dv/abpwm_host_model.sv
// Host model: command bytes and the sleep level
// Assumes core_clk from the bench, one byte per cycle at most
`timescale 1ns/1ns
`default_nettype none
module abpwm_host_model (
	input wire logic core_clk,
	output logic cmd_valid,
	output logic cmd_dcx,
	output logic cmd_wr,
	output logic [7:0] cmd_data,
	output logic sleep_mode
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_dcx = 1'b0;
		cmd_wr = 1'b0;
		cmd_data = 8'h00;
		sleep_mode = 1'b1;
	end
	////////////////////////////////
	// Byte held until the next edge
	task automatic put(input logic dcx, input logic wr, input logic [7:0] d);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_dcx <= dcx;
		cmd_wr <= wr;
		cmd_data <= d;
	endtask : put
	// Released bus shows inverted data
	task automatic idle();
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		cmd_data <= ~cmd_data;
	endtask : idle
	task automatic set_sleep(input logic s);
		@(posedge core_clk);
		sleep_mode <= s;
	endtask : set_sleep
	task automatic wr_ctrl(input logic [7:0] p1, input logic [7:0] duty, input logic [7:0] aux, input logic [7:0] ctl);
		logic s;
		s = sleep_mode;
		set_sleep(1'b1);
		put(1'b0, 1'b0, 8'hb9);
		put(1'b1, 1'b1, p1);
		put(1'b1, 1'b1, duty);
		put(1'b1, 1'b1, aux);
		put(1'b1, 1'b1, ctl);
		idle();
		set_sleep(s);
	endtask : wr_ctrl
endmodule : abpwm_host_model
`default_nettype wire

// file: dv/tb.sv
// Bench: reference model checks of the backlight PWM block
// Assumes the host model owns the command bus and sleep level
`timescale 1ns/1ns
`default_nettype none
`include "abpwm_regs.svh"
module tb;
	logic core_clk, resetn, core_ce, display_on, pwm_on_request, adaptive_backlight_enable, frame_start;
	logic cmd_valid, cmd_dcx, cmd_wr, sleep_mode, rsp_valid, led_pwm_output, led_pwm_pin_oe;
	logic interp_two_point, setting_inhibited;
	logic [7:0] cmd_data, adaptive_backlight_factor, threshold_target, rsp_data, pwm_readback_value, duty, ctl;
	logic [8:0] white_threshold_level;
	logic [4:0] counter_gap_half, antiwhite_coeff;
	logic [39:0] gamma_ref_values;
	logic [7:0] m8[12];
	logic [7:0] q[$];
	logic [7:0] rq[$];
	logic [31:0] r;
	int seed = 32'h19bdf361;
	int failures, checks, k, i, b, n, lv, st, ed;
	abpwm_host_model u_abpwm_host_model (.core_clk, .cmd_valid, .cmd_dcx, .cmd_wr, .cmd_data, .sleep_mode);
	abpwm_top u_abpwm_top (.core_clk, .resetn, .core_ce, .cmd_valid, .cmd_dcx, .cmd_wr, .cmd_data, .sleep_mode,
		.display_on, .pwm_on_request, .adaptive_backlight_enable, .adaptive_backlight_factor, .frame_start,
		.threshold_target, .rsp_valid, .rsp_data, .led_pwm_output, .led_pwm_pin_oe, .pwm_readback_value,
		.white_threshold_level, .interp_two_point, .counter_gap_half, .antiwhite_coeff, .gamma_ref_values,
		.setting_inhibited);
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		if (rsp_valid === 1'b1)
			rq.push_back(rsp_data);
	initial
	begin
		#100000;
		failures++;
		stop_test();
	end
	////////////////////////////////
	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
		checks++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Parameter writes with random idle gaps
	task automatic wr(input logic [7:0] code, input logic [7:0] d[$]);
		u_abpwm_host_model.put(1'b0, 1'b0, code);
		foreach (d[j])
		begin
			r = $random(seed);
			if (r[0])
				u_abpwm_host_model.idle();
			u_abpwm_host_model.put(1'b1, 1'b1, d[j]);
		end
		u_abpwm_host_model.idle();
	endtask : wr
	// Back to back reads, answers gathered by the monitor
	task automatic rd(input logic [7:0] code, input logic [7:0] e[$]);
		rq = {};
		u_abpwm_host_model.put(1'b0, 1'b0, code);
		foreach (e[j])
			u_abpwm_host_model.put(1'b1, 1'b0, 8'h00);
		u_abpwm_host_model.idle();
		repeat (2) @(posedge core_clk);
		chk("rsp_count", e.size(), rq.size());
		foreach (e[j])
			chk("rsp_data", e[j], rq[j]);
	endtask : rd
	////////////////////////////////
	initial
	begin
		resetn = 1'b0;
		core_ce = 1'b1;
		display_on = 1'b0;
		pwm_on_request = 1'b0;
		adaptive_backlight_enable = 1'b0;
		adaptive_backlight_factor = 8'h00;
		frame_start = 1'b0;
		threshold_target = 8'h00;
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		rd(`ABPWM_CMD_PWM_CTRL, '{8'h00, 8'h00, 8'h00, 8'h00});
		chk("pin_oe", 1'b0, led_pwm_pin_oe);
		// Bank cases: zero step, zero gap, coefficient limits
		for (k = 0; k < 6; k++)
		begin
			b = k % 2;
			q = {};
			for (i = 0; i < 11; i++)
			begin
				r = $random(seed);
				m8[i] = r[7:0] & (i inside {[1:4]} ? 8'h1f : i == 5 ? 8'h03 : 8'hff);
			end
			m8[5][2] = k[0];
			if (k > 3)
			begin
				m8[0] |= 8'h11;
				m8[1 + b] |= 8'h01;
				m8[3 + b] = k == 4 ? 8'h10 : 8'h00;
			end
			if (k == 1)
				m8[0] &= 8'h0f;
			if (k == 2)
				m8[1] = 8'h00;
			if (k == 3)
				m8[4] = 8'h11;
			if (k == 5)
				m8[2] = 8'h10;
			for (i = 0; i < 11; i++)
				q.push_back(m8[i]);
			q.push_back(8'h5a);
			wr(`ABPWM_CMD_ADAPT, q);
			q[11] = 8'h00;
			rd(`ABPWM_CMD_ADAPT, q);
			st = b ? m8[0][7:4] : m8[0][3:0];
			chk("inhibit", st == 0 || m8[1 + b] == 0 || m8[3 + b] > 8'h10, setting_inhibited);
			chk("gap", m8[1 + b], counter_gap_half);
			chk("coef", m8[3 + b], antiwhite_coeff);
			chk("interp", m8[5][b], interp_two_point);
			chk("gamma", {m8[10], m8[9], m8[8], m8[7], m8[6]}, gamma_ref_values);
		end
		// Threshold walk, up then down to a clamp
		lv = 0;
		for (k = 0; k < 10; k++)
		begin
			r = $random(seed);
			@(posedge core_clk);
			if (k % 5 == 0)
				threshold_target <= k ? {3'b000, r[4:0]} : r[7:0];
			frame_start <= 1'b1;
			@(posedge core_clk);
			frame_start <= 1'b0;
			repeat (20) @(posedge core_clk);
			n = 2 * threshold_target;
			lv = lv < n ? (lv + st < n ? lv + st : n) : (lv - st > n ? lv - st : n);
			chk("threshold", lv, white_threshold_level);
		end
		// Frozen clock enable holds the threshold level
		@(posedge core_clk);
		core_ce <= 1'b0;
		threshold_target <= ~threshold_target;
		frame_start <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("ce_hold", lv, white_threshold_level);
		core_ce <= 1'b1;
		frame_start <= 1'b0;
		// Gating, sleep, pin enable and duty scaling
		for (k = 0; k < 3; k++)
		begin
			r = $random(seed);
			duty = k == 0 ? 8'hff : r[7:0];
			ctl = k == 0 ? 8'hff : k == 1 ? 8'h08 : 8'h10;
			u_abpwm_host_model.wr_ctrl(r[15:8], duty, r[23:16], ctl);
			rd(`ABPWM_CMD_PWM_CTRL, '{8'h00, duty, r[23:16], ctl & `ABPWM_CTRL_MASK});
			chk("pin_oe", ctl[3], led_pwm_pin_oe);
			for (i = 0; i < 8; i++)
			begin
				r = $random(seed);
				@(posedge core_clk);
				display_on <= i[0];
				pwm_on_request <= i[1];
				adaptive_backlight_enable <= r[8];
				adaptive_backlight_factor <= r[7:0];
				u_abpwm_host_model.set_sleep(i[2]);
				repeat (4) @(posedge core_clk);
				ed = !r[8] || r[7:0] == 8'hff ? duty : duty * r[7:0] / 256;
				chk("readback", ed, pwm_readback_value);
				n = 0;
				repeat (255)
				begin
					@(posedge core_clk);
					n += led_pwm_output === 1'b1;
				end
				chk("led_high", ctl[3] && !i[2] && (ctl[4] ? i[1] : i[0]) ? ed : 0, n);
			end
		end
		stop_test();
	end
endmodule : tb
`default_nettype wire
